// ==== tsw_map.svh ====
// constants for the tdm switch configuration selector
`ifndef TSW_MAP_SVH
`define TSW_MAP_SVH
`define TSW_RATE_2M 2'h0
`define TSW_RATE_4M 2'h1
`define TSW_RATE_8M 2'h2
`define TSW_ARRB_8X8 2'h0
`define TSW_ARRB_16X8 2'h1
`define TSW_ARRB_PAIR 2'h2
`define TSW_ARRB_NIB 2'h3
`define TSW_N_IN 16
`define TSW_N_OUT 10
`define TSW_SLOTS_2M 8'h20
`define TSW_SLOTS_4M 8'h40
`define TSW_SLOTS_8M 8'h80
`define TSW_SLOTS_NIB 8'h40
`define TSW_CAP_512 10'h200
`define TSW_CAP_256 10'h100
`define TSW_CAP_128 10'h080
`define TSW_PAIR_MIN 4'h2
`define TSW_PAIR_MAX 4'h9
`define TSW_RST_RRS 1'h0
`define TSW_RST_ARRB 2'h0
`define TSW_RST_IN_RATE 2'h0
`define TSW_RST_OUT_RATE 2'h0
`define TSW_RST_PAIR 8'h32
`endif

// ==== tsw_pkg.sv ====
// types shared by the tdm switch configuration selector
package tsw_pkg;
  typedef enum logic [2:0] {
    TSW_ARR_8X8,
    TSW_ARR_16X8,
    TSW_ARR_PAIR,
    TSW_ARR_NIB,
    TSW_ARR_4M_8X4,
    TSW_ARR_4M_4X4,
    TSW_ARR_8M_2X2,
    TSW_ARR_DIFF
  } tsw_arr_t;

  typedef enum logic {
    TSW_PH_IDLE,
    TSW_PH_RUN
  } tsw_phase_t;

  typedef struct packed {
    tsw_arr_t arrangement;
    logic [1:0] in_rate;
    logic [1:0] out_rate;
    logic [4:0] n_in;
    logic [3:0] n_out;
    logic [7:0] in_slots;
    logic [7:0] out_slots;
    logic [9:0] cap_in;
    logic [9:0] cap_out;
    logic non_blocking;
    logic delay_sel_ok;
    logic nibble;
    logic clk_8m;
    logic cfg_error;
  } tsw_cfg_t;

  typedef struct packed {
    logic msg_mode;
    logic delay_const;
    logic drive_en;
    logic [3:0] stream;
    logic [6:0] chan;
  } tsw_ctl_word_t;
endpackage

// ==== tsw_buf2.sv ====
// two-entry valid/ready buffer
`timescale 1ns/1ps
module tsw_buf2 #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] count;
  } tsw_buf_st_t;

  tsw_buf_st_t st;
  tsw_buf_st_t next_st;
  logic push;
  logic pop;

  assign in_ready = (st.count != 2'h2);
  assign out_valid = (st.count != 2'h0);
  assign out_data = st.mem[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (pop)
    begin
      next_st.mem[0] = st.mem[1];
    end
    if (push)
    begin
      // entry index after any pop
      if ((st.count == 2'h0) || (st.count == 2'h1 && pop))
      begin
        next_st.mem[0] = in_data;
      end
      else
      begin
        next_st.mem[1] = in_data;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

// ==== tsw_config_select.sv ====
// switching configuration decode and channel control word conditioning
`timescale 1ns/1ps
`include "tsw_map.svh"

// Function
// - identical rates: 2.048 Mb/s arrangement chosen by the two arrangement bits, 4.096 Mb/s by bit 0
// - different rates: always non-blocking, stream counts from rate fields
// - identical rates: common rate from input field, output field ignored
// - 2.048 Mb/s: 8x8, 16x8, stream-pair or nibble arrangement
// - 8x8: 8 in, 8 out, 32 slots, non-blocking, delay choice allowed
// - 16x8: 512x256 blocking, multiplexed bus only, variable delay forced
// - pair mode: pairs 0,1 fixed plus pairs A,B from 2..9, 128x128
// - nibble: 64 nibble slots, 8 in by 4 out, 512x256 blocking
// - 4.096 Mb/s: 8x4 or 4x4, 64 channels per stream
// - 4.096 Mb/s 8x4: 512x256 blocking, variable delay forced
// - 4.096 Mb/s 4x4: 256x256 non-blocking, delay choice honoured
// - 8.192 Mb/s: 2 in, 2 out, 128 slots, bits ignored, 8.192 MHz
// - different rates: arrangement bits ignored, rates from both fields
// - different rates: 256x256 non-blocking with delay choice
// - device derives active stream counts from the written rates
// - rate relation bit selects identical or different rate operation
// - control word carries delay type, message mode and driver enable
module tsw_config_select (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mode_write,
  input wire logic rate_relation_select,
  input wire logic [1:0] switch_arrangement_bits,
  input wire logic [1:0] input_rate_field,
  input wire logic [1:0] output_rate_field,
  input wire logic pair_write,
  input wire logic [7:0] pair_selection_register,
  input wire logic mux_bus_mode,
  output logic config_loaded,
  output tsw_pkg::tsw_cfg_t cfg,
  output logic [`TSW_N_IN-1:0] in_stream_enable,
  output logic [`TSW_N_OUT-1:0] out_stream_enable,
  output logic pair_select_error,
  input wire logic ctl_in_valid,
  output logic ctl_in_ready,
  input wire tsw_pkg::tsw_ctl_word_t ctl_in,
  output logic ctl_out_valid,
  input wire logic ctl_out_ready,
  output tsw_pkg::tsw_ctl_word_t ctl_out
);
  typedef struct packed {
    tsw_pkg::tsw_phase_t phase;
    logic rrs;
    logic [1:0] arr_code;
    logic [1:0] in_code;
    logic [1:0] out_code;
    logic [7:0] pair_sel;
    tsw_pkg::tsw_cfg_t cfg;
    logic [`TSW_N_IN-1:0] in_mask;
    logic [`TSW_N_OUT-1:0] out_mask;
    logic pair_err;
  } tsw_st_t;

  tsw_st_t st;
  tsw_st_t next_st;
  tsw_pkg::tsw_cfg_t dec;
  tsw_pkg::tsw_ctl_word_t cond_word;
  logic [`TSW_N_IN-1:0] dec_in_mask;
  logic [`TSW_N_OUT-1:0] dec_out_mask;
  logic [3:0] pair_a;
  logic [3:0] pair_b;
  logic pair_a_ok;
  logic pair_b_ok;
  logic buf_in_ready;
  logic accept;
  logic [`TSW_N_IN-1:0] out_mask_wide;

  assign pair_a = st.pair_sel[3:0];
  assign pair_b = st.pair_sel[7:4];
  assign pair_a_ok = (pair_a >= `TSW_PAIR_MIN) && (pair_a <= `TSW_PAIR_MAX);
  assign pair_b_ok = (pair_b >= `TSW_PAIR_MIN) && (pair_b <= `TSW_PAIR_MAX);
  // padded so every 4-bit stream index lands inside the mask
  assign out_mask_wide = {{(`TSW_N_IN-`TSW_N_OUT){1'b0}}, st.out_mask};

  // slot count of one stream at a given rate
  function automatic logic [7:0] slots_of(input logic [1:0] rate);
    logic [7:0] s;
    s = `TSW_SLOTS_2M;
    case (rate)
      `TSW_RATE_4M: s = `TSW_SLOTS_4M;
      `TSW_RATE_8M: s = `TSW_SLOTS_8M;
      default: s = `TSW_SLOTS_2M;
    endcase
    return s;
  endfunction

  // decode of the stored mode fields
  always_comb
  begin
    dec = '0;
    dec.in_rate = st.in_code;
    dec.out_rate = st.in_code;
    dec.cap_in = `TSW_CAP_256;
    dec.cap_out = `TSW_CAP_256;
    dec.non_blocking = 1'b1;
    dec.delay_sel_ok = 1'b1;
    if (!st.rrs)
    begin
      // output field not consulted here
      dec.in_slots = slots_of(st.in_code);
      dec.out_slots = slots_of(st.in_code);
      case (st.in_code)
        `TSW_RATE_2M:
        begin
          case (st.arr_code)
            `TSW_ARRB_8X8:
            begin
              dec.arrangement = tsw_pkg::TSW_ARR_8X8;
              dec.n_in = 5'h08;
              dec.n_out = 4'h8;
            end
            `TSW_ARRB_16X8:
            begin
              dec.arrangement = tsw_pkg::TSW_ARR_16X8;
              dec.n_in = 5'h10;
              dec.n_out = 4'h8;
              dec.cap_in = `TSW_CAP_512;
              dec.non_blocking = 1'b0;
              dec.delay_sel_ok = 1'b0;
              dec.cfg_error = !mux_bus_mode;
            end
            `TSW_ARRB_PAIR:
            begin
              dec.arrangement = tsw_pkg::TSW_ARR_PAIR;
              dec.n_in = 5'h04;
              dec.n_out = 4'h4;
              dec.cap_in = `TSW_CAP_128;
              dec.cap_out = `TSW_CAP_128;
            end
            default:
            begin
              dec.arrangement = tsw_pkg::TSW_ARR_NIB;
              dec.nibble = 1'b1;
              dec.n_in = 5'h08;
              dec.n_out = 4'h4;
              dec.in_slots = `TSW_SLOTS_NIB;
              dec.out_slots = `TSW_SLOTS_NIB;
              dec.cap_in = `TSW_CAP_512;
              dec.non_blocking = 1'b0;
              dec.delay_sel_ok = 1'b0;
            end
          endcase
        end
        `TSW_RATE_4M:
        begin
          dec.n_out = 4'h4;
          // bit 0 set picks 4x4, clear picks 8x4
          if (st.arr_code[0])
          begin
            dec.arrangement = tsw_pkg::TSW_ARR_4M_4X4;
            dec.n_in = 5'h04;
          end
          else
          begin
            dec.arrangement = tsw_pkg::TSW_ARR_4M_8X4;
            dec.n_in = 5'h08;
            dec.cap_in = `TSW_CAP_512;
            dec.non_blocking = 1'b0;
            dec.delay_sel_ok = 1'b0;
          end
        end
        `TSW_RATE_8M:
        begin
          // arrangement bits disregarded
          dec.arrangement = tsw_pkg::TSW_ARR_8M_2X2;
          dec.n_in = 5'h02;
          dec.n_out = 4'h2;
          dec.clk_8m = 1'b1;
        end
        default:
        begin
          // reserved rate code
          dec.arrangement = tsw_pkg::TSW_ARR_8X8;
          dec.cfg_error = 1'b1;
        end
      endcase
    end
    else
    begin
      // arrangement bits disregarded
      dec.arrangement = tsw_pkg::TSW_ARR_DIFF;
      dec.out_rate = st.out_code;
      dec.in_slots = slots_of(st.in_code);
      dec.out_slots = slots_of(st.out_code);
      dec.n_in = 5'h08;
      dec.n_out = 4'h8;
      case ({st.in_code, st.out_code})
        {`TSW_RATE_2M, `TSW_RATE_4M}:
        begin
          dec.n_out = 4'h4;
        end
        {`TSW_RATE_2M, `TSW_RATE_8M}:
        begin
          dec.n_out = 4'h2;
          dec.clk_8m = 1'b1;
        end
        {`TSW_RATE_4M, `TSW_RATE_2M}:
        begin
          dec.n_in = 5'h04;
        end
        {`TSW_RATE_8M, `TSW_RATE_2M}:
        begin
          dec.n_in = 5'h02;
          dec.clk_8m = 1'b1;
        end
        default:
        begin
          // rate pair with no defined conversion
          dec.cfg_error = 1'b1;
        end
      endcase
    end
  end

  // per-stream enables
  genvar i;
  generate
    for (i = 0; i < `TSW_N_IN; i = i + 1)
    begin : g_stream
      localparam logic [3:0] IDX = 4'(i);
      logic pair_hit;
      // pairs 0 and 1 always present
      assign pair_hit = (IDX < `TSW_PAIR_MIN) ||
        (pair_a_ok && pair_a == IDX) || (pair_b_ok && pair_b == IDX);
      assign dec_in_mask[i] = (dec.arrangement == tsw_pkg::TSW_ARR_PAIR) ?
        pair_hit : (5'(i) < dec.n_in);
      if (i < `TSW_N_OUT)
      begin : g_out
        assign dec_out_mask[i] =
          (dec.arrangement == tsw_pkg::TSW_ARR_PAIR) ?
          pair_hit : (IDX < dec.n_out);
      end
    end
  endgenerate

  // control word conditioning
  always_comb
  begin
    cond_word = ctl_in;
    if (!st.cfg.delay_sel_ok)
    begin
      cond_word.delay_const = 1'b0;
    end
    if (ctl_in.stream >= 4'(`TSW_N_OUT))
    begin
      cond_word.drive_en = 1'b0;
    end
    else if (!out_mask_wide[ctl_in.stream])
    begin
      cond_word.drive_en = 1'b0;
    end
  end

  // words held off until the mode has been programmed
  assign ctl_in_ready = buf_in_ready && (st.phase == tsw_pkg::TSW_PH_RUN);
  assign accept = ctl_in_valid && (st.phase == tsw_pkg::TSW_PH_RUN);

  always_comb
  begin
    next_st = st;
    // mode fields stored on the strobe
    if (mode_write)
    begin
      next_st.rrs = rate_relation_select;
      next_st.arr_code = switch_arrangement_bits;
      next_st.in_code = input_rate_field;
      next_st.out_code = output_rate_field;
    end
    if (pair_write)
    begin
      next_st.pair_sel = pair_selection_register;
    end
    next_st.cfg = dec;
    next_st.in_mask = dec_in_mask;
    next_st.out_mask = dec_out_mask;
    // pair mode needs two distinct pairs in range
    next_st.pair_err = (dec.arrangement == tsw_pkg::TSW_ARR_PAIR) &&
      !(pair_a_ok && pair_b_ok && pair_a != pair_b);
    // leaves idle on the first mode write
    case (st.phase)
      tsw_pkg::TSW_PH_IDLE:
      begin
        if (mode_write)
        begin
          next_st.phase = tsw_pkg::TSW_PH_RUN;
        end
      end
      tsw_pkg::TSW_PH_RUN:
      begin
        next_st.phase = tsw_pkg::TSW_PH_RUN;
      end
      default:
      begin
        next_st.phase = tsw_pkg::TSW_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.phase <= tsw_pkg::TSW_PH_IDLE;
      st.rrs <= `TSW_RST_RRS;
      st.arr_code <= `TSW_RST_ARRB;
      st.in_code <= `TSW_RST_IN_RATE;
      st.out_code <= `TSW_RST_OUT_RATE;
      st.pair_sel <= `TSW_RST_PAIR;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign config_loaded = (st.phase == tsw_pkg::TSW_PH_RUN);
  assign cfg = st.cfg;
  assign in_stream_enable = st.in_mask;
  assign out_stream_enable = st.out_mask;
  assign pair_select_error = st.pair_err;

  tsw_buf2 #(
    .W($bits(tsw_pkg::tsw_ctl_word_t))
  ) tsw_buf2_inst (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(accept),
    .in_ready(buf_in_ready),
    .in_data(cond_word),
    .out_valid(ctl_out_valid),
    .out_ready(ctl_out_ready),
    .out_data(ctl_out)
  );
endmodule

// ==== tsw_cs_asserts.sv ====
// checker for the configuration selector ports
`timescale 1ns/1ps
`include "tsw_map.svh"
module tsw_cs_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mode_write,
  input wire logic rate_relation_select,
  input wire logic [1:0] switch_arrangement_bits,
  input wire logic [1:0] input_rate_field,
  input wire logic [1:0] output_rate_field,
  input wire logic config_loaded,
  input wire tsw_pkg::tsw_cfg_t cfg,
  input wire logic [`TSW_N_IN-1:0] in_stream_enable,
  input wire logic [`TSW_N_OUT-1:0] out_stream_enable,
  input wire logic ctl_in_valid,
  input wire logic ctl_in_ready,
  input wire tsw_pkg::tsw_ctl_word_t ctl_in,
  input wire logic ctl_out_valid,
  input wire logic ctl_out_ready,
  input wire tsw_pkg::tsw_ctl_word_t ctl_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_w8;
    mode_write && !rate_relation_select && input_rate_field == 2'h2;
  endsequence
  sequence s_acc;
    ctl_in_valid && ctl_in_ready && !ctl_out_valid;
  endsequence
  property p_rdy;
    !config_loaded |-> !ctl_in_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready before load");
  property p_hold;
    ctl_out_valid && !ctl_out_ready |=> ctl_out_valid && $stable(ctl_out);
  endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_8m;
    s_w8 |-> ##2 cfg.n_in == 5'h2 && cfg.n_out == 4'h2
      && cfg.in_slots == 8'h80 && cfg.clk_8m;
  endproperty
  a_8m: assert property (p_8m) else $error("8m decode wrong");
  property p_dif;
    mode_write && rate_relation_select && input_rate_field == 2'h0
      && output_rate_field == 2'h1 |-> ##2 cfg.n_in == 5'h8
      && cfg.n_out == 4'h4 && cfg.non_blocking && cfg.delay_sel_ok;
  endproperty
  a_dif: assert property (p_dif) else $error("2 to 4 wrong");
  property p_16;
    mode_write && !rate_relation_select && input_rate_field == 2'h0
      && switch_arrangement_bits == 2'h1 |-> ##2 !cfg.non_blocking
      && !cfg.delay_sel_ok && cfg.cap_in == 10'h200;
  endproperty
  a_16: assert property (p_16) else $error("16x8 wrong");
  property p_nib;
    cfg.arrangement == tsw_pkg::TSW_ARR_NIB |-> cfg.n_in == 5'h8
      && cfg.n_out == 4'h4 && cfg.in_slots == 8'h40 && !cfg.non_blocking;
  endproperty
  a_nib: assert property (p_nib) else $error("nibble wrong");
  property p_pair;
    cfg.arrangement == tsw_pkg::TSW_ARR_PAIR |-> cfg.cap_in == 10'h080
      && in_stream_enable[1:0] == 2'h3 && out_stream_enable[1:0] == 2'h3;
  endproperty
  a_pair: assert property (p_pair) else $error("pair wrong");
  property p_8x8;
    cfg.arrangement == tsw_pkg::TSW_ARR_8X8 && cfg.n_in != 5'h0
      |-> cfg.n_in == 5'h8 && cfg.in_slots == 8'h20
      && in_stream_enable == 16'h00ff && out_stream_enable == 10'h0ff;
  endproperty
  a_8x8: assert property (p_8x8) else $error("8x8 wrong");
  property p_dly;
    s_acc and !cfg.delay_sel_ok |=> !ctl_out.delay_const;
  endproperty
  a_dly: assert property (p_dly) else $error("delay not forced");
  property p_drv;
    s_acc and ctl_in.stream > 4'h9 |=> !ctl_out.drive_en;
  endproperty
  a_drv: assert property (p_drv) else $error("drive not off");
endmodule
bind tsw_config_select tsw_cs_asserts tsw_cs_asserts_inst (
  .clk(clk), .rst_b(rst_b), .mode_write(mode_write),
  .rate_relation_select(rate_relation_select),
  .switch_arrangement_bits(switch_arrangement_bits),
  .input_rate_field(input_rate_field),
  .output_rate_field(output_rate_field),
  .config_loaded(config_loaded), .cfg(cfg),
  .in_stream_enable(in_stream_enable),
  .out_stream_enable(out_stream_enable),
  .ctl_in_valid(ctl_in_valid), .ctl_in_ready(ctl_in_ready),
  .ctl_in(ctl_in), .ctl_out_valid(ctl_out_valid),
  .ctl_out_ready(ctl_out_ready), .ctl_out(ctl_out)
);

// ==== tsw_sink.sv ====
// output channel logic model taking control words
`timescale 1ns/1ps
module tsw_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic valid,
  input wire tsw_pkg::tsw_ctl_word_t data,
  output logic ready
);
  tsw_pkg::tsw_ctl_word_t q[$];
  assign ready = !stall;
  always @(posedge clk)
  begin
    if (valid && ready)
    begin
      q.push_back(data);
    end
  end
endmodule

// ==== tsw_config_select_tb_top.sv ====
// testbench for the configuration selector
`timescale 1ns/1ps
module tsw_config_select_tb_top;
  typedef struct packed {
    tsw_pkg::tsw_arr_t a;
    logic [4:0] ni;
    logic [3:0] no;
    logic [7:0] sl;
    logic [1:0] f;
  } tsw_exp_t;
  logic clk = 1'b0;
  logic rst_b, mode_write, rate_relation_select, pair_write, mux_bus_mode;
  logic [1:0] switch_arrangement_bits, input_rate_field, output_rate_field;
  logic [7:0] pair_selection_register;
  logic config_loaded, pair_select_error, stall;
  tsw_pkg::tsw_cfg_t cfg;
  logic [15:0] in_stream_enable;
  logic [9:0] out_stream_enable;
  logic ctl_in_valid, ctl_in_ready, ctl_out_valid, ctl_out_ready;
  tsw_pkg::tsw_ctl_word_t ctl_in, ctl_out;
  int num_errors = 0;
  int comparisons = 0;
  logic [6:0] md [11];
  tsw_exp_t ex [11];
  logic [14:0] xo [11];
  always #5 clk = ~clk;
  tsw_config_select tsw_config_select_inst (
    .clk(clk), .rst_b(rst_b), .mode_write(mode_write),
    .rate_relation_select(rate_relation_select),
    .switch_arrangement_bits(switch_arrangement_bits),
    .input_rate_field(input_rate_field),
    .output_rate_field(output_rate_field), .pair_write(pair_write),
    .pair_selection_register(pair_selection_register),
    .mux_bus_mode(mux_bus_mode), .config_loaded(config_loaded),
    .cfg(cfg), .in_stream_enable(in_stream_enable),
    .out_stream_enable(out_stream_enable),
    .pair_select_error(pair_select_error), .ctl_in_valid(ctl_in_valid),
    .ctl_in_ready(ctl_in_ready), .ctl_in(ctl_in),
    .ctl_out_valid(ctl_out_valid), .ctl_out_ready(ctl_out_ready),
    .ctl_out(ctl_out)
  );
  tsw_sink tsw_sink_inst (
    .clk(clk), .stall(stall), .valid(ctl_out_valid), .data(ctl_out),
    .ready(ctl_out_ready)
  );
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wmode(input logic [6:0] m);
    @(negedge clk);
    {rate_relation_select, switch_arrangement_bits} = m[6:4];
    {input_rate_field, output_rate_field} = m[3:0];
    mode_write = 1'b1;
    @(negedge clk);
    mode_write = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task wpair(input logic [7:0] p);
    @(negedge clk);
    pair_selection_register = p;
    pair_write = 1'b1;
    @(negedge clk);
    pair_write = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task send(input tsw_pkg::tsw_ctl_word_t w);
    int n;
    n = 0;
    @(negedge clk);
    ctl_in = w;
    ctl_in_valid = 1'b1;
    while (ctl_in_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 50)
    begin
      num_errors++;
      conclude;
    end
    @(negedge clk);
    ctl_in_valid = 1'b0;
  endtask
  task drain(input int k);
    int n;
    n = 0;
    stall = 1'b0;
    while (tsw_sink_inst.q.size() < k && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 50)
    begin
      num_errors++;
      conclude;
    end
  endtask
  initial
  begin
    {rst_b, mode_write, rate_relation_select, pair_write} = 4'h0;
    {switch_arrangement_bits, input_rate_field, output_rate_field} = 6'h0;
    {mux_bus_mode, stall, ctl_in_valid} = 3'h4;
    pair_selection_register = 8'h32;
    ctl_in = '0;
    md = '{7'h03, 7'h10, 7'h20, 7'h30, 7'h06, 7'h14, 7'h38, 7'h51,
      7'h62, 7'h74, 7'h48};
    ex[0] = '{tsw_pkg::TSW_ARR_8X8, 5'h8, 4'h8, 8'h20, 2'h3};
    ex[1] = '{tsw_pkg::TSW_ARR_16X8, 5'h10, 4'h8, 8'h20, 2'h0};
    ex[2] = '{tsw_pkg::TSW_ARR_PAIR, 5'h4, 4'h4, 8'h20, 2'h3};
    ex[3] = '{tsw_pkg::TSW_ARR_NIB, 5'h8, 4'h4, 8'h40, 2'h0};
    ex[4] = '{tsw_pkg::TSW_ARR_4M_8X4, 5'h8, 4'h4, 8'h40, 2'h0};
    ex[5] = '{tsw_pkg::TSW_ARR_4M_4X4, 5'h4, 4'h4, 8'h40, 2'h3};
    ex[6] = '{tsw_pkg::TSW_ARR_8M_2X2, 5'h2, 4'h2, 8'h80, 2'h3};
    ex[7] = '{tsw_pkg::TSW_ARR_DIFF, 5'h8, 4'h4, 8'h20, 2'h3};
    ex[8] = '{tsw_pkg::TSW_ARR_DIFF, 5'h8, 4'h2, 8'h20, 2'h3};
    ex[9] = '{tsw_pkg::TSW_ARR_DIFF, 5'h4, 4'h8, 8'h40, 2'h3};
    ex[10] = '{tsw_pkg::TSW_ARR_DIFF, 5'h2, 4'h8, 8'h80, 2'h3};
    xo = '{15'h1000, 15'h1000, 15'h1000, 15'h2020, 15'h2005, 15'h2005,
      15'h404a, 15'h2001, 15'h4042, 15'h1004, 15'h1048};
    repeat (10) @(negedge clk);
    chk(ctl_in_ready, 32'h0);
    rst_b = 1'b1;
    ctl_in_valid = 1'b1;
    repeat (2) @(negedge clk);
    chk(ctl_in_ready, 32'h0);
    chk({config_loaded, ctl_out_valid}, 32'h0);
    ctl_in_valid = 1'b0;
    chk(cfg.n_in, 32'h8);
    for (int i = 0; i < 11; i++)
    begin
      wmode(md[i]);
      chk({cfg.out_slots, cfg.clk_8m, cfg.nibble, cfg.cfg_error,
        cfg.in_rate, cfg.out_rate}, xo[i]);
      chk({cfg.arrangement, cfg.n_in, cfg.n_out, cfg.in_slots,
        cfg.non_blocking, cfg.delay_sel_ok}, ex[i]);
      chk(in_stream_enable, ex[i].a == tsw_pkg::TSW_ARR_PAIR ? 32'hf
        : (32'h1 << ex[i].ni) - 32'h1);
      chk(out_stream_enable, ex[i].a == tsw_pkg::TSW_ARR_PAIR ? 32'hf
        : (32'h1 << ex[i].no) - 32'h1);
    end
    chk(config_loaded, 32'h1);
    mux_bus_mode = 1'b0;
    wmode(7'h10);
    chk(cfg.cfg_error, 32'h1);
    mux_bus_mode = 1'b1;
    wmode(7'h0c);
    chk({cfg.cfg_error, in_stream_enable}, 32'h10000);
    wmode(7'h40);
    chk(cfg.cfg_error, 32'h1);
    wmode(7'h20);
    wpair(8'h95);
    chk({in_stream_enable, out_stream_enable}, {16'h0223, 10'h223});
    chk(pair_select_error, 32'h0);
    wpair(8'h44);
    chk(pair_select_error, 32'h1);
    wpair(8'h1a);
    chk(pair_select_error, 32'h1);
    wmode(7'h10);
    stall = 1'b1;
    send({3'h7, 4'h3, 7'h05});
    send({3'h3, 4'hc, 7'h7f});
    chk(ctl_in_ready, 32'h0);
    drain(2);
    chk(tsw_sink_inst.q[0], {3'h5, 4'h3, 7'h05});
    chk(tsw_sink_inst.q[1], {3'h0, 4'hc, 7'h7f});
    wmode(7'h00);
    send({3'h3, 4'h2, 7'h1f});
    send({3'h3, 4'h9, 7'h01});
    drain(4);
    chk(tsw_sink_inst.q[2], {3'h3, 4'h2, 7'h1f});
    chk(tsw_sink_inst.q[3], {3'h2, 4'h9, 7'h01});
    wmode(7'h06);
    send({3'h7, 4'h3, 7'h00});
    drain(5);
    chk(tsw_sink_inst.q[4], {3'h5, 4'h3, 7'h00});
    wmode(7'h14);
    send({3'h7, 4'h4, 7'h02});
    drain(6);
    chk(tsw_sink_inst.q[5], {3'h6, 4'h4, 7'h02});
    conclude;
  end
endmodule
